// ---- core/fspd_core.sv ----
// Summary of operation
// - in any suspend, all nine array read instructions are accepted
// - erase suspend only: program, write enable, nested suspend, lock
// - any suspend: status, function read, error clear, resume
// - any suspend: identification, unique number, parameter table reads
// - soft reset acts only when 99h follows 66h with no accepted instruction between
// - any suspend: volatile sets, readbacks, info row, autoboot, nop
// - power-down needs exactly the opcode, then chip select high
// - power-down is reached within the entry delay after select rises
// - in power-down only the release instruction is recognised
// - release completes after the release delay; nothing accepted before
// - release instruction is ignored while a write is in progress
// - read register: wrap in 2:0, dummy in 6:3, pin select in 7
// - nonvolatile set writes both copies, volatile set only volatile
// - settings 0-3 continuous, 4-7 wrap at 8, 16, 32, 64 bytes
// - without wrap the read address simply increments
// - with wrap the address cycles within its aligned burst window
// - wrap stays until cleared, power-down or reset
// - drive bits: 85h writes both copies, 83h only volatile
// - drive strength defaults to half, reducible to one eighth
// - nonvolatile sets need the write enable latch; volatile do not
// - function register bits 2 and 3 show program/erase suspended
`timescale 1ns/1ps

module fspd_link
    import fspd_pkg::*;
(
    // serial link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    // from the core domain
    input wire logic done_tgl,
    // quasi-static frame, stable once the clock stops
    output fspd_frame_type frame
);

    fspd_link_type s_reg;
    fspd_link_type s_next;

    always_comb begin
        s_next = s_reg;
        s_next.done_s1 = done_tgl;
        s_next.done_s2 = s_reg.done_s1;
        if (s_reg.cnt != 5'h1f) begin
            s_next.cnt = s_reg.cnt + 5'h01;
        end
        s_next.frm.len = s_next.cnt;
        // frame tag copies the core's toggle, so idle frames are not rerun
        if (s_reg.cnt == OPCODE_BITS - 5'h01) begin
            s_next.frm.tag = s_reg.done_s2;
        end
        if (s_reg.cnt < OPCODE_BITS) begin
            s_next.frm.opc = {s_reg.frm.opc[6:0], mosi};
        end else if (s_reg.cnt < DATA_END_BITS) begin
            s_next.frm.dat = {s_reg.frm.dat[6:0], mosi};
        end
    end

    // only the bit counter is cleared by a high select; the frame must
    // survive it so the core can read it after the clock has stopped
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            s_reg.cnt <= 5'h00;
        end else begin
            s_reg <= s_next;
        end
    end

    assign frame = s_reg.frm;

endmodule : fspd_link

module fspd_core
    import fspd_pkg::*;
#(
    parameter int ADDR_W = 20
)
(
    // system
    input wire logic MCLK,
    input wire logic RESET,
    // serial link
    input wire logic SCK,
    input wire logic CS_N,
    input wire logic MOSI,
    // array engine state
    input wire logic WRITE_IN_PROGRESS_FLAG,
    input wire logic PROG_SUSPENDED,
    input wire logic ERASE_SUSPENDED,
    // read address sequencing
    input wire logic RD_ADDR_LOAD,
    input wire logic [ADDR_W-1:0] RD_ADDR_START,
    input wire logic RD_ADDR_STEP,
    // decoded instruction
    output logic CMD_ACCEPT,
    output logic CMD_IGNORE,
    output logic [7:0] CMD_CODE,
    output logic [7:0] CMD_DATA,
    output logic SOFT_RESET,
    output logic NV_WRITE,
    // mode and configuration
    output logic POWER_DOWN,
    output logic RELEASE_BUSY,
    output logic WRITE_ENABLE_LATCH,
    output logic [7:0] FUNC_SUSPEND_BITS,
    output logic [7:0] READ_PARAMS,
    output logic [7:0] READ_PARAMS_NV,
    output logic [2:0] DRIVE_STRENGTH,
    output logic [2:0] DRIVE_STRENGTH_NV,
    output logic [ADDR_W-1:0] READ_ADDR
);

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_s3;
        fspd_frame_type frm_s1;
        fspd_frame_type frm_s2;
        logic done;
        logic write_enable_latch;
        logic arm;
        logic pd;
        logic pd_ent;
        logic rel;
        logic [TIMER_W-1:0] tmr;
        logic [7:0] rr_v;
        logic [7:0] rr_nv;
        logic [2:0] ds_v;
        logic [2:0] ds_nv;
        logic accept;
        logic ignore;
        logic [7:0] code;
        logic [7:0] data;
        logic srst;
        logic nvw;
        logic [7:0] func;
        logic [ADDR_W-1:0] addr;
    } fspd_core_type;

    fspd_core_type r_reg;
    fspd_core_type r_next;
    fspd_frame_type link_frame;

    fspd_link u_link (
        .sck(SCK),
        .cs_n(CS_N),
        .mosi(MOSI),
        .done_tgl(r_reg.done),
        .frame(link_frame)
    );

    function automatic logic permitted(
        input logic [7:0] c,
        input logic erase_susp
    );
        logic ok;
        ok = 1'b0;
        case (c)
            NORMAL_ARRAY_READ_CMD, FAST_ARRAY_READ_CMD,
            DUAL_IO_FAST_READ_CMD, DUAL_OUTPUT_FAST_READ_CMD,
            QUAD_IO_FAST_READ_CMD, QUAD_OUTPUT_FAST_READ_CMD,
            DOUBLE_RATE_FAST_READ_CMD, DUAL_DOUBLE_RATE_READ_CMD,
            QUAD_DOUBLE_RATE_READ_CMD: ok = 1'b1;
            STATUS_READ_CMD, FUNCTION_REG_READ_CMD, ERROR_BIT_CLEAR_CMD,
            RESUME_CMD_A, RESUME_CMD_B: ok = 1'b1;
            POWER_DOWN_RELEASE_CMD, STANDARD_IDENT_READ_CMD,
            MAKER_DEVICE_IDENT_READ_CMD, QUAD_STANDARD_IDENT_READ_CMD,
            UNIQUE_NUMBER_READ_CMD,
            DISCOVERABLE_PARAM_READ_CMD: ok = 1'b1;
            SOFT_RESET_ARM_CMD, SOFT_RESET_GO_CMD: ok = 1'b1;
            VOLATILE_READ_PARAM_SET_A, VOLATILE_READ_PARAM_SET_B,
            VOLATILE_EXT_PARAM_SET, READ_PARAM_READBACK,
            EXT_PARAM_READBACK, INFO_ROW_READ_CMD, AUTOBOOT_REG_READ_CMD,
            NO_OPERATION_CMD: ok = 1'b1;
            PAGE_PROGRAM_CMD, QUAD_PAGE_PROGRAM_CMD_A,
            QUAD_PAGE_PROGRAM_CMD_B, WRITE_ENABLE_CMD, SUSPEND_CMD_A,
            SUSPEND_CMD_B, SECTOR_RELEASE_CMD,
            SECTOR_GUARD_CMD: ok = erase_susp;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : permitted

    function automatic logic [ADDR_W-1:0] next_addr(
        input logic [ADDR_W-1:0] a,
        input logic [7:0] rr
    );
        logic [ADDR_W-1:0] m;
        logic [ADDR_W-1:0] inc;
        m = '0;
        inc = a + {{(ADDR_W-1){1'b0}}, 1'b1};
        case (rr[WRAP_LEN_LSB +: 2])
            2'h0: m[2:0] = 3'h7;
            2'h1: m[3:0] = 4'hf;
            2'h2: m[4:0] = 5'h1f;
            2'h3: m[5:0] = 6'h3f;
        endcase
        // every burst window is aligned, so it never crosses a page
        if (rr[WRAP_ENABLE_BIT]) begin
            return (a & ~m) | (inc & m);
        end
        return inc;
    endfunction : next_addr

    logic ev;
    logic suspended;
    logic [7:0] c;

    always_comb begin
        r_next = r_reg;
        r_next.cs_s1 = CS_N;
        r_next.cs_s2 = r_reg.cs_s1;
        r_next.cs_s3 = r_reg.cs_s2;
        r_next.frm_s1 = link_frame;
        r_next.frm_s2 = r_reg.frm_s1;
        r_next.accept = 1'b0;
        r_next.ignore = 1'b0;
        r_next.srst = 1'b0;
        r_next.nvw = 1'b0;
        r_next.func = 8'h00;
        r_next.func[PROGRAM_SUSPENDED_BIT] = PROG_SUSPENDED;
        r_next.func[ERASE_SUSPENDED_BIT] = ERASE_SUSPENDED;
        suspended = PROG_SUSPENDED | ERASE_SUSPENDED;
        c = r_reg.frm_s2.opc;
        // a frame runs once, at the select rise, with at least an opcode
        ev = r_reg.cs_s2 & ~r_reg.cs_s3 &
             (r_reg.frm_s2.tag == r_reg.done) &
             (r_reg.frm_s2.len >= OPCODE_BITS);
        if (r_reg.cs_s2 & ~r_reg.cs_s3 &
            (r_reg.frm_s2.tag == r_reg.done)) begin
            r_next.done = ~r_reg.done;
        end

        if (r_reg.pd_ent) begin
            if (r_reg.tmr == '0) begin
                r_next.pd_ent = 1'b0;
                r_next.pd = 1'b1;
                r_next.rr_v = r_reg.rr_nv;
            end else begin
                r_next.tmr = r_reg.tmr - 1'b1;
            end
        end
        if (r_reg.rel) begin
            if (r_reg.tmr == '0) begin
                r_next.rel = 1'b0;
                r_next.pd = 1'b0;
            end else begin
                r_next.tmr = r_reg.tmr - 1'b1;
            end
        end

        if (ev) begin
            r_next.code = c;
            r_next.data = r_reg.frm_s2.dat;
            if (r_reg.pd_ent | r_reg.rel) begin
                r_next.ignore = 1'b1;
            end else if (r_reg.pd) begin
                if (c == POWER_DOWN_RELEASE_CMD && !WRITE_IN_PROGRESS_FLAG) begin
                    r_next.rel = 1'b1;
                    r_next.tmr = TIMER_W'(RELEASE_CYCLES - 1);
                    r_next.accept = 1'b1;
                end else begin
                    r_next.ignore = 1'b1;
                end
            end else if (c == POWER_DOWN_RELEASE_CMD && WRITE_IN_PROGRESS_FLAG) begin
                r_next.ignore = 1'b1;
            end else if (suspended &&
                         !permitted(c, ERASE_SUSPENDED)) begin
                r_next.ignore = 1'b1;
            end else begin
                r_next.accept = 1'b1;
                r_next.arm = (c == SOFT_RESET_ARM_CMD);
                case (c)
                    POWER_DOWN_ENTRY_CMD: begin
                        // extra clocks after the opcode mean it never latched
                        if (r_reg.frm_s2.len == OPCODE_BITS) begin
                            r_next.pd_ent = 1'b1;
                            // the select synchroniser eats part of the budget
                            r_next.tmr = TIMER_W'(ENTRY_CYCLES - ENTRY_LATENCY);
                        end else begin
                            r_next.accept = 1'b0;
                            r_next.ignore = 1'b1;
                        end
                    end
                    WRITE_ENABLE_CMD: begin
                        r_next.write_enable_latch = 1'b1;
                    end
                    VOLATILE_READ_PARAM_SET_A,
                    VOLATILE_READ_PARAM_SET_B: begin
                        if (r_reg.frm_s2.len >= DATA_END_BITS) begin
                            r_next.rr_v = r_reg.frm_s2.dat;
                        end
                    end
                    NONVOLATILE_READ_PARAM_SET: begin
                        if (r_reg.write_enable_latch &&
                            r_reg.frm_s2.len >= DATA_END_BITS) begin
                            r_next.rr_v = r_reg.frm_s2.dat;
                            r_next.rr_nv = r_reg.frm_s2.dat;
                            r_next.write_enable_latch = 1'b0;
                            r_next.nvw = 1'b1;
                        end
                    end
                    VOLATILE_EXT_PARAM_SET: begin
                        if (r_reg.frm_s2.len >= DATA_END_BITS) begin
                            r_next.ds_v = r_reg.frm_s2.dat[
                                DRIVE_STRENGTH_LSB +: 3];
                        end
                    end
                    NONVOLATILE_EXT_PARAM_SET: begin
                        if (r_reg.write_enable_latch &&
                            r_reg.frm_s2.len >= DATA_END_BITS) begin
                            r_next.ds_v = r_reg.frm_s2.dat[
                                DRIVE_STRENGTH_LSB +: 3];
                            r_next.ds_nv = r_reg.frm_s2.dat[
                                DRIVE_STRENGTH_LSB +: 3];
                            r_next.write_enable_latch = 1'b0;
                            r_next.nvw = 1'b1;
                        end
                    end
                    SOFT_RESET_GO_CMD: begin
                        if (r_reg.arm) begin
                            r_next.srst = 1'b1;
                            r_next.write_enable_latch = 1'b0;
                            r_next.rr_v = r_reg.rr_nv;
                            r_next.ds_v = r_reg.ds_nv;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        if (RD_ADDR_LOAD) begin
            r_next.addr = RD_ADDR_START;
        end else if (RD_ADDR_STEP) begin
            r_next.addr = next_addr(r_reg.addr, r_reg.rr_v);
        end

        if (RESET) begin
            r_next = '0;
            r_next.cs_s1 = 1'b1;
            r_next.cs_s2 = 1'b1;
            r_next.cs_s3 = 1'b1;
            r_next.rr_v = READ_PARAM_RESET;
            r_next.rr_nv = READ_PARAM_RESET;
            r_next.ds_v = DRIVE_STRENGTH_RESET;
            r_next.ds_nv = DRIVE_STRENGTH_RESET;
        end
    end

    always_ff @(posedge MCLK) begin
        r_reg <= r_next;
    end

    assign CMD_ACCEPT = r_reg.accept;
    assign CMD_IGNORE = r_reg.ignore;
    assign CMD_CODE = r_reg.code;
    assign CMD_DATA = r_reg.data;
    assign SOFT_RESET = r_reg.srst;
    assign NV_WRITE = r_reg.nvw;
    assign POWER_DOWN = r_reg.pd;
    assign RELEASE_BUSY = r_reg.rel;
    assign WRITE_ENABLE_LATCH = r_reg.write_enable_latch;
    assign FUNC_SUSPEND_BITS = r_reg.func;
    // bit layout carries wrap, dummy count and pin function as stored
    assign READ_PARAMS = r_reg.rr_v;
    assign READ_PARAMS_NV = r_reg.rr_nv;
    assign DRIVE_STRENGTH = r_reg.ds_v;
    assign DRIVE_STRENGTH_NV = r_reg.ds_nv;
    assign READ_ADDR = r_reg.addr;

endmodule : fspd_core

// ---- core/fspd_pkg.sv ----
package fspd_pkg;

    // instruction codes
    localparam logic [7:0] NORMAL_ARRAY_READ_CMD = 8'h03;
    localparam logic [7:0] FAST_ARRAY_READ_CMD = 8'h0b;
    localparam logic [7:0] DUAL_IO_FAST_READ_CMD = 8'hbb;
    localparam logic [7:0] DUAL_OUTPUT_FAST_READ_CMD = 8'h3b;
    localparam logic [7:0] QUAD_IO_FAST_READ_CMD = 8'heb;
    localparam logic [7:0] QUAD_OUTPUT_FAST_READ_CMD = 8'h6b;
    localparam logic [7:0] DOUBLE_RATE_FAST_READ_CMD = 8'h0d;
    localparam logic [7:0] DUAL_DOUBLE_RATE_READ_CMD = 8'hbd;
    localparam logic [7:0] QUAD_DOUBLE_RATE_READ_CMD = 8'hed;
    localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
    localparam logic [7:0] QUAD_PAGE_PROGRAM_CMD_A = 8'h32;
    localparam logic [7:0] QUAD_PAGE_PROGRAM_CMD_B = 8'h38;
    localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] FUNCTION_REG_READ_CMD = 8'h48;
    localparam logic [7:0] ERROR_BIT_CLEAR_CMD = 8'h82;
    localparam logic [7:0] RESUME_CMD_A = 8'h7a;
    localparam logic [7:0] RESUME_CMD_B = 8'h30;
    localparam logic [7:0] SUSPEND_CMD_A = 8'h75;
    localparam logic [7:0] SUSPEND_CMD_B = 8'hb0;
    localparam logic [7:0] POWER_DOWN_RELEASE_CMD = 8'hab;
    localparam logic [7:0] STANDARD_IDENT_READ_CMD = 8'h9f;
    localparam logic [7:0] MAKER_DEVICE_IDENT_READ_CMD = 8'h90;
    localparam logic [7:0] QUAD_STANDARD_IDENT_READ_CMD = 8'haf;
    localparam logic [7:0] UNIQUE_NUMBER_READ_CMD = 8'h4b;
    localparam logic [7:0] DISCOVERABLE_PARAM_READ_CMD = 8'h5a;
    localparam logic [7:0] SOFT_RESET_ARM_CMD = 8'h66;
    localparam logic [7:0] SOFT_RESET_GO_CMD = 8'h99;
    localparam logic [7:0] VOLATILE_READ_PARAM_SET_A = 8'hc0;
    localparam logic [7:0] VOLATILE_READ_PARAM_SET_B = 8'h63;
    localparam logic [7:0] NONVOLATILE_READ_PARAM_SET = 8'h65;
    localparam logic [7:0] VOLATILE_EXT_PARAM_SET = 8'h83;
    localparam logic [7:0] NONVOLATILE_EXT_PARAM_SET = 8'h85;
    localparam logic [7:0] READ_PARAM_READBACK = 8'h61;
    localparam logic [7:0] EXT_PARAM_READBACK = 8'h81;
    localparam logic [7:0] INFO_ROW_READ_CMD = 8'h68;
    localparam logic [7:0] AUTOBOOT_REG_READ_CMD = 8'h14;
    localparam logic [7:0] NO_OPERATION_CMD = 8'h00;
    localparam logic [7:0] SECTOR_RELEASE_CMD = 8'h26;
    localparam logic [7:0] SECTOR_GUARD_CMD = 8'h24;
    localparam logic [7:0] POWER_DOWN_ENTRY_CMD = 8'hb9;

    // frame lengths in serial bits
    localparam logic [4:0] OPCODE_BITS = 5'h08;
    localparam logic [4:0] DATA_END_BITS = 5'h10;

    // read register fields
    localparam int WRAP_LEN_LSB = 0;
    localparam int WRAP_ENABLE_BIT = 2;
    localparam int DUMMY_LSB = 3;
    localparam int PIN_FUNCTION_SELECT_BIT = 7;
    localparam int DRIVE_STRENGTH_LSB = 5;
    localparam logic [7:0] READ_PARAM_RESET = 8'h00;
    // drive code for the half-strength default
    localparam logic [2:0] DRIVE_STRENGTH_RESET = 3'h4;
    localparam int PROGRAM_SUSPENDED_BIT = 2;
    localparam int ERASE_SUSPENDED_BIT = 3;

    // timing
    localparam int MCLK_PERIOD_NS = 25;
    localparam int POWER_DOWN_ENTRY_DELAY_NS = 3000;
    localparam int POWER_DOWN_RELEASE_DELAY_NS = 5000;
    // entry is a longest time: round down
    localparam int ENTRY_CYCLES =
        POWER_DOWN_ENTRY_DELAY_NS / MCLK_PERIOD_NS;
    // release is a least time: round up
    localparam int RELEASE_CYCLES =
        (POWER_DOWN_RELEASE_DELAY_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int TIMER_W = 12;
    // mclk edges from select rise until the entry timer is loaded (3), plus the edge that sets pd
    localparam int ENTRY_LATENCY = 4;

    typedef struct packed {
        logic tag;
        logic [4:0] len;
        logic [7:0] opc;
        logic [7:0] dat;
    } fspd_frame_type;

    typedef struct packed {
        logic [4:0] cnt;
        logic done_s1;
        logic done_s2;
        fspd_frame_type frm;
    } fspd_link_type;

endpackage : fspd_pkg

// ---- tb/fspd_core_sva.sv ----
`timescale 1ns/1ps
module fspd_core_sva
    import fspd_pkg::*;
#(
    parameter int ADDR_W = 20
)
(
    // system
    input wire logic MCLK,
    input wire logic RESET,
    // engine and address inputs
    input wire logic PROG_SUSPENDED,
    input wire logic ERASE_SUSPENDED,
    input wire logic RD_ADDR_LOAD,
    input wire logic [ADDR_W-1:0] RD_ADDR_START,
    input wire logic RD_ADDR_STEP,
    // decoded results
    input wire logic CMD_ACCEPT,
    input wire logic CMD_IGNORE,
    input wire logic [7:0] CMD_CODE,
    input wire logic SOFT_RESET,
    input wire logic NV_WRITE,
    // mode and configuration
    input wire logic POWER_DOWN,
    input wire logic RELEASE_BUSY,
    input wire logic WRITE_ENABLE_LATCH,
    input wire logic [7:0] FUNC_SUSPEND_BITS,
    input wire logic [7:0] READ_PARAMS,
    input wire logic [ADDR_W-1:0] READ_ADDR
);
    // accept shows three edges after select rise, which starts the budget
    localparam int ENTRY_MAX = ENTRY_CYCLES - 3;
    logic [11:0] busy_cnt;

    function automatic logic [ADDR_W-1:0] step_addr(
        input logic [ADDR_W-1:0] a, input logic [7:0] rr);
        logic [ADDR_W-1:0] m;
        m = ADDR_W'((8 << rr[1:0]) - 1);
        return rr[2] ? (a & ~m) | ((a + 1'b1) & m) : a + 1'b1;
    endfunction : step_addr

    always_ff @(posedge MCLK) begin
        if (RESET || !RELEASE_BUSY) busy_cnt <= 12'h000;
        else busy_cnt <= busy_cnt + 12'h001;
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);

    chk_pulse_excl: assert property (
        !(CMD_ACCEPT && CMD_IGNORE)) else $error("accept with ignore");
    chk_susp_flags: assert property (
        !$past(RESET) |-> FUNC_SUSPEND_BITS == {4'h0,
        $past(ERASE_SUSPENDED), $past(PROG_SUSPENDED), 2'h0})
        else $error("suspend bits wrong");
    chk_addr_load: assert property (
        RD_ADDR_LOAD |=> READ_ADDR == $past(RD_ADDR_START))
        else $error("address not loaded");
    chk_addr_step: assert property (
        RD_ADDR_STEP && !RD_ADDR_LOAD |=>
        READ_ADDR == step_addr($past(READ_ADDR), $past(READ_PARAMS)))
        else $error("address step wrong");
    chk_entry_time: assert property (
        CMD_ACCEPT && CMD_CODE == POWER_DOWN_ENTRY_CMD && !POWER_DOWN
        |-> ##[1:ENTRY_MAX] POWER_DOWN) else $error("power-down late");
    chk_pd_only_rel: assert property (
        POWER_DOWN && CMD_ACCEPT |-> CMD_CODE == POWER_DOWN_RELEASE_CMD)
        else $error("accepted in power-down");
    chk_busy_quiet: assert property (
        RELEASE_BUSY && $past(RELEASE_BUSY) |-> !CMD_ACCEPT)
        else $error("accepted during release");
    chk_busy_len: assert property (
        $fell(RELEASE_BUSY) && !$past(RESET) |->
        busy_cnt >= RELEASE_CYCLES) else $error("release too short");
    chk_rel_end: assert property (
        $fell(POWER_DOWN) && !$past(RESET) |->
        $past(RELEASE_BUSY) || $past(RELEASE_BUSY, 2))
        else $error("left power-down without release");
    chk_soft_reset: assert property (
        SOFT_RESET |-> CMD_CODE == SOFT_RESET_GO_CMD)
        else $error("reset without go code");
    chk_nv_wel: assert property (
        NV_WRITE |-> $past(WRITE_ENABLE_LATCH) ||
        $past(WRITE_ENABLE_LATCH, 2)) else $error("nv write without latch");
endmodule : fspd_core_sva

bind fspd_core fspd_core_sva #(.ADDR_W(ADDR_W)) u_sva (
    .MCLK, .RESET, .PROG_SUSPENDED, .ERASE_SUSPENDED, .RD_ADDR_LOAD,
    .RD_ADDR_START, .RD_ADDR_STEP, .CMD_ACCEPT, .CMD_IGNORE, .CMD_CODE,
    .SOFT_RESET, .NV_WRITE, .POWER_DOWN, .RELEASE_BUSY,
    .WRITE_ENABLE_LATCH, .FUNC_SUSPEND_BITS, .READ_PARAMS, .READ_ADDR);

// ---- tb/fspd_core_tb.sv ----
`timescale 1ns/1ps
module fspd_core_tb
    import fspd_pkg::*;
;
    localparam int AW = 20;
    logic mclk, reset, write_in_progress_flag, program_suspended_flag, erase_suspended_flag, load, step;
    logic sck, cs_n, mosi, acc, ign, srst, pd, busy, write_enable_latch, nvw;
    logic [7:0] code, cdat, fsb, rp, rpn, d, d2, d3;
    logic [2:0] ds, dsn;
    logic [AW-1:0] start, rd_addr, a;
    logic [8:0] e;
    logic [8:0] exq[$];
    logic [7:0] ok_any[$] = '{8'h03, 8'h0b, 8'hbb, 8'h3b, 8'heb, 8'h6b,
        8'h0d, 8'hbd, 8'hed, 8'h05, 8'h48, 8'h82, 8'h7a, 8'h30, 8'hab,
        8'h9f, 8'h90, 8'haf, 8'h4b, 8'h5a, 8'hc0, 8'h63, 8'h83, 8'h61,
        8'h81, 8'h68, 8'h14, 8'h00, 8'h99, 8'h66, 8'h99};
    logic [7:0] ok_erase[$] = '{8'h02, 8'h32, 8'h38, 8'h06, 8'h75, 8'hb0,
        8'h26, 8'h24};
    logic [7:0] not_ok[$] = '{8'h20, 8'hd8, 8'h65, 8'h85, 8'hb9};
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    int n_srst = 0;
    int n_nvw = 0;

    fspd_host host (.sck(sck), .cs_n(cs_n), .mosi(mosi));

    fspd_core #(.ADDR_W(AW)) dut (
        .MCLK(mclk), .RESET(reset), .SCK(sck), .CS_N(cs_n), .MOSI(mosi),
        .WRITE_IN_PROGRESS_FLAG(write_in_progress_flag), .PROG_SUSPENDED(program_suspended_flag), .ERASE_SUSPENDED(erase_suspended_flag),
        .RD_ADDR_LOAD(load), .RD_ADDR_START(start), .RD_ADDR_STEP(step),
        .CMD_ACCEPT(acc), .CMD_IGNORE(ign), .CMD_CODE(code),
        .CMD_DATA(cdat), .SOFT_RESET(srst), .NV_WRITE(nvw),
        .POWER_DOWN(pd), .RELEASE_BUSY(busy), .WRITE_ENABLE_LATCH(write_enable_latch),
        .FUNC_SUSPEND_BITS(fsb), .READ_PARAMS(rp), .READ_PARAMS_NV(rpn),
        .DRIVE_STRENGTH(ds), .DRIVE_STRENGTH_NV(dsn), .READ_ADDR(rd_addr));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] x,
        input logic [7:0] r);
        logic [AW-1:0] m;
        m = AW'((8 << r[1:0]) - 1);
        return r[2] ? (x & ~m) | ((x + 1'b1) & m) : x + 1'b1;
    endfunction : nxt

    task check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task final_report;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    task tick(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask : tick

    // random lead-in keeps the link edges drifting against mclk
    task frame(input logic [7:0] op, input logic [7:0] dv, input int n,
        input logic ok);
        if (n >= 8) exq.push_back({ok, op});
        #($urandom_range(20));
        host.send({op, dv}, n);
        tick(12);
    endtask : frame

    always @(negedge mclk) begin
        if (!reset && (acc === 1'b1 || ign === 1'b1)) begin
            if (exq.size() == 0) begin
                check("spare result", {acc, ign}, 2'b00);
            end else begin
                e = exq.pop_front();
                check("accept", acc, e[8]);
                if (e[8]) check("code", code, e[7:0]);
            end
        end
        if (srst === 1'b1) n_srst++;
        if (nvw === 1'b1) n_nvw++;
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            final_report();
        end
    end

    initial begin
        reset = 1'b1;
        {write_in_progress_flag, program_suspended_flag, erase_suspended_flag, load, step} = 5'h00;
        start = '0;
        void'($urandom(32'h27fc73b5));
        repeat (2) @(posedge mclk);
        #2;
        reset = 1'b0;
        tick(2);
        check("rp reset", rp, READ_PARAM_RESET);
        check("drive reset", ds, DRIVE_STRENGTH_RESET);
        frame(8'h05, 8'h00, 5, 1'b0);
        d = 8'($urandom);
        frame(8'hc0, d, 16, 1'b1);
        check("rp", rp, d);
        check("data", cdat, d);
        check("rp nv", rpn, READ_PARAM_RESET);
        frame(8'h65, ~d, 16, 1'b1);
        check("rp nv no wel", rpn, READ_PARAM_RESET);
        d2 = 8'($urandom) | 8'h05;
        frame(8'h06, 8'h00, 8, 1'b1);
        frame(8'h65, d2, 16, 1'b1);
        check("rp both", {rp, rpn}, {d2, d2});
        check("wel cleared", write_enable_latch, 1'b0);
        d3 = 8'($urandom);
        frame(8'h83, d3, 16, 1'b1);
        check("drive", {ds, dsn}, {d3[7:5], DRIVE_STRENGTH_RESET});
        frame(8'h06, 8'h00, 8, 1'b1);
        frame(8'h85, ~d3, 16, 1'b1);
        check("drive both", {ds, dsn}, {~d3[7:5], ~d3[7:5]});
        for (int k = 0; k < 8; k++) begin
            d = (8'($urandom) & 8'hf8) | 8'(k);
            frame(k[0] ? 8'h63 : 8'hc0, d, 16, 1'b1);
            check("rp wrap", rp, d);
            a = AW'($urandom);
            start = a;
            load = 1'b1;
            tick(1);
            load = 1'b0;
            step = 1'b1;
            check("addr load", rd_addr, a);
            for (int i = 0; i < 70; i++) begin
                tick(1);
                a = nxt(a, d);
                check("addr", rd_addr, a);
            end
            step = 1'b0;
        end
        for (int p = 0; p < 2; p++) begin
            erase_suspended_flag = (p == 0);
            program_suspended_flag = (p == 1);
            tick(4);
            check("susp bits", fsb, p ? 8'h04 : 8'h08);
            foreach (ok_any[i]) frame(ok_any[i], 8'h00, 8, 1'b1);
            foreach (ok_erase[i]) frame(ok_erase[i], 8'h00, 8, p == 0);
            foreach (not_ok[i]) frame(not_ok[i], 8'h00, 8, 1'b0);
        end
        {erase_suspended_flag, program_suspended_flag} = 2'b00;
        check("soft resets", n_srst, 2);
        check("nv writes", n_nvw, 2);
        check("nv kept", {rpn, dsn}, {d2, ~d3[7:5]});
        frame(8'hc0, 8'h06, 16, 1'b1);
        frame(8'hb9, 8'h00, 9, 1'b0);
        check("no pd", pd, 1'b0);
        frame(8'hb9, 8'h00, 8, 1'b1);
        for (int i = 0; i < ENTRY_CYCLES && pd !== 1'b1; i++) tick(1);
        check("pd", pd, 1'b1);
        frame(8'h05, 8'h00, 8, 1'b0);
        frame(8'h06, 8'h00, 8, 1'b0);
        write_in_progress_flag = 1'b1;
        frame(8'hab, 8'h00, 8, 1'b0);
        check("pd busy wip", {pd, busy}, 2'b10);
        write_in_progress_flag = 1'b0;
        frame(8'hab, 8'h00, 8, 1'b1);
        check("busy", busy, 1'b1);
        frame(8'h05, 8'h00, 8, 1'b0);
        for (int i = 0; i < 400 && pd !== 1'b0; i++) tick(1);
        check("released", {pd, busy}, 2'b00);
        check("rp reload", rp, d2);
        frame(8'h05, 8'h00, 8, 1'b1);
        check("pending", exq.size(), 0);
        final_report();
    end
endmodule : fspd_core_tb

// ---- tb/fspd_host.sv ----
`timescale 1ns/1ps
module fspd_host (
    // serial link
    output logic sck,
    output logic cs_n,
    output logic mosi
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b1;
    end

    // clock runs only inside a frame; data flips after the last clock, before select rises
    task send(input logic [15:0] w, input int n);
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            mosi = w[15-i];
            #62.5 sck = 1'b1;
            #62.5 sck = 1'b0;
        end
        mosi = ~mosi;
        #62.5 cs_n = 1'b1;
    endtask : send
endmodule : fspd_host
